// [core/slts_regs.v]
// link test pattern, status and power-down register bank with lane byte source
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "slts_regs.vh"

// Function
// - selector 0 normal data, 1 PRBS7, 2 PRBS15, 3 PRBS23 on lanes
// - selector 4 ramp, 5 transport test, 6 repeated D21.5, 7 repeated K28.5
// - selector 8 repeated ILA, 9 modified RPAT, 10 low, 11 high, 12-15 reserved
// - link A sends the device number, link B sends it plus one
// - device number bit 0 ignored and reads zero
// - end-of-frame select 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved
// - end-of-frame character replaces frame-end data only when monitoring permits
// - status bit 6 reads one while the link is up
// - status bit 5 reads live sync level, 0 while request asserted
// - status bit 4 sticky on sysref phase shift, write one clears
// - status bit 3 set by first sysref after enable, write one clears
// - status bit 2 reads one while serializer PLL locked
// - power-down bit 1 powers down channel B and its lanes
// - power-down bit 0 powers down channel A and its lanes
// - both channels down powers down whole link, PLL and multiframe counter
// - channel B down with both on link A leaves B slots undefined
// - link disabled holds link logic and counter in reset, ignores sysref
module slts_regs (
    ref_clk,
    rst,
    regAddr,
    regWrData,
    regWrStb,
    regRdStb,
    regRdData,
    serialLinkEnable,
    linkUpIn,
    syncNIn,
    sysrefEvent,
    sysrefPhaseShift,
    pllLockedIn,
    normalData,
    frameEndIn,
    eofPermitted,
    testPatternSel,
    laneData_r,
    laneIsK_r,
    laneForceLow,
    laneForceHigh,
    ilaRepeatMode,
    transportTestMode,
    rpatMode,
    ilaDevNumA,
    ilaDevNumB,
    chanAPowerDown,
    chanBPowerDown,
    laneAPowerDown,
    laneBPowerDown,
    subsysPowerDown,
    linkLogicReset,
    chanBSlotsUndefined
);
    input  wire                     ref_clk;
    input  wire                     rst;
    input  wire [`SLTS_ADDR_W-1:0]  regAddr;
    input  wire [7:0]               regWrData;
    input  wire                     regWrStb;
    input  wire                     regRdStb;
    output reg  [7:0]               regRdData;

    // link status and lane inputs
    input  wire                     serialLinkEnable;
    input  wire                     linkUpIn;
    input  wire                     syncNIn;
    input  wire                     sysrefEvent;
    input  wire                     sysrefPhaseShift;
    input  wire                     pllLockedIn;
    input  wire [7:0]               normalData;
    input  wire                     frameEndIn;
    input  wire                     eofPermitted;

    // pattern and lane outputs
    output wire [3:0]               testPatternSel;
    output reg  [7:0]               laneData_r;
    output reg                      laneIsK_r;
    output wire                     laneForceLow;
    output wire                     laneForceHigh;
    output wire                     ilaRepeatMode;
    output wire                     transportTestMode;
    output wire                     rpatMode;
    output wire [7:0]               ilaDevNumA;
    output wire [7:0]               ilaDevNumB;

    // power-down and link hold outputs
    output wire                     chanAPowerDown;
    output wire                     chanBPowerDown;
    output wire                     laneAPowerDown;
    output wire                     laneBPowerDown;
    output wire                     subsysPowerDown;
    output wire                     linkLogicReset;
    output wire                     chanBSlotsUndefined;

    // ****************************************************
    // functions
    // ****************************************************
    // advance the shared lfsr by eight bits for the chosen prbs order
    function [22:0] prbsAdvance;
        input [22:0] seed;
        input [3:0]  mode;
        reg   [22:0] s;
        reg          fb;
        integer      i;
        begin
            s = seed;
            // one shift per lane bit, taps set by the order
            for (i = 0; i < 8; i = i + 1) begin
                case (mode)
                    `SLTS_TP_PRBS7:  fb = s[6] ^ s[5];
                    `SLTS_TP_PRBS15: fb = s[14] ^ s[13];
                    default:         fb = s[22] ^ s[17];
                endcase
                s = {s[21:0], fb};
            end
            prbsAdvance = s;
        end
    endfunction

    // map the end-of-frame select to its control byte
    function [7:0] eofChar;
        input [1:0] sel;
        begin
            case (sel)
                `SLTS_FC_K281: eofChar = `SLTS_CH_K281;
                `SLTS_FC_K285: eofChar = `SLTS_CH_K285;
                default:       eofChar = `SLTS_CH_K287;
            endcase
        end
    endfunction

    // ****************************************************
    // register storage
    // ****************************************************
    reg [3:0]  testSel_r;
    reg [6:0]  devNum_r;
    reg [1:0]  frame_end_char_select_r;
    reg [1:0]  pwrDn_r;
    reg        realigned_r;
    reg        lmfc_phase_set_flag_r;
    reg        sysrefSeen_r;
    reg [22:0] lfsr_r;
    reg [7:0]  ramp_r;
    reg [7:0]  rpat_r;

    wire       wrTest;
    wire       wrDevNum;
    wire       wrFchar;
    wire       wrStatus;
    wire       wrPwrDn;
    wire       bothDown;
    wire       linkActive;
    wire       realignSet;
    wire       alignSet;
    wire [7:0] statusWord;

    // address decode of write strobes
    assign wrTest   = regWrStb && (regAddr == `SLTS_OFF_TEST);
    assign wrDevNum = regWrStb && (regAddr == `SLTS_OFF_DEVNUM);
    assign wrFchar  = regWrStb && (regAddr == `SLTS_OFF_FRAME_END_CHAR_SELECT);
    assign wrStatus = regWrStb && (regAddr == `SLTS_OFF_STATUS);
    assign wrPwrDn  = regWrStb && (regAddr == `SLTS_OFF_PWRDN);

    // control registers, reserved bits are not stored
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            testSel_r <= `SLTS_RST_TEST;
            devNum_r  <= `SLTS_RST_DEVNUM;
            frame_end_char_select_r   <= `SLTS_RST_FRAME_END_CHAR_SELECT;
            pwrDn_r   <= `SLTS_RST_PWRDN;
        end else begin
            if (wrTest) begin
                testSel_r <= regWrData[3:0];
            end
            if (wrDevNum) begin
                devNum_r <= regWrData[7:1];
            end
            if (wrFchar) begin
                frame_end_char_select_r <= regWrData[1:0];
            end
            if (wrPwrDn) begin
                pwrDn_r <= regWrData[1:0];
            end
        end
    end

    // ****************************************************
    // link power and enable
    // ****************************************************
    // both channels down takes the whole link out
    assign bothDown        = pwrDn_r[`SLTS_PD_A] & pwrDn_r[`SLTS_PD_B];
    assign subsysPowerDown = bothDown;
    assign linkActive      = serialLinkEnable & ~bothDown;
    assign linkLogicReset  = ~linkActive;
    assign chanAPowerDown  = pwrDn_r[`SLTS_PD_A];
    assign chanBPowerDown  = pwrDn_r[`SLTS_PD_B];
    assign laneAPowerDown  = pwrDn_r[`SLTS_PD_A] | ~linkActive;
    assign laneBPowerDown  = pwrDn_r[`SLTS_PD_B] | ~linkActive;
    // channel B slots still go out on link A but carry no valid samples
    assign chanBSlotsUndefined = pwrDn_r[`SLTS_PD_B] & ~pwrDn_r[`SLTS_PD_A];

    // ****************************************************
    // alignment flags
    // ****************************************************
    // sysref only counts while the link runs
    assign realignSet = linkActive & sysrefPhaseShift;
    assign alignSet   = linkActive & sysrefEvent & ~sysrefSeen_r;

    // sticky flags: a set in the clearing cycle wins
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            realigned_r  <= 1'b0;
            lmfc_phase_set_flag_r    <= 1'b0;
            sysrefSeen_r <= 1'b0;
        end else begin
            // phase shift sets, write one clears
            if (realignSet) begin
                realigned_r <= 1'b1;
            end else if (wrStatus && regWrData[`SLTS_ST_REALIGN]) begin
                realigned_r <= 1'b0;
            end
            // only the first event after enable sets
            if (alignSet) begin
                lmfc_phase_set_flag_r <= 1'b1;
            end else if (wrStatus && regWrData[`SLTS_ST_ALIGN]) begin
                lmfc_phase_set_flag_r <= 1'b0;
            end
            // re-arm the first-event detector each time the link drops
            if (!linkActive) begin
                sysrefSeen_r <= 1'b0;
            end else if (sysrefEvent) begin
                sysrefSeen_r <= 1'b1;
            end
        end
    end

    // live and sticky status bits, reserved bits read zero
    assign statusWord = {1'b0,
                         linkUpIn & linkActive,
                         syncNIn,
                         realigned_r,
                         lmfc_phase_set_flag_r,
                         pllLockedIn & ~bothDown,
                         2'b00};

    // ****************************************************
    // read port
    // ****************************************************
    // read data stand one cycle after the strobe, zero otherwise
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRdStb) begin
            case (regAddr)
                `SLTS_OFF_TEST:   regRdData <= {4'h0, testSel_r};
                `SLTS_OFF_DEVNUM: regRdData <= {devNum_r, 1'b0};
                `SLTS_OFF_FRAME_END_CHAR_SELECT:  regRdData <= {6'h00, frame_end_char_select_r};
                `SLTS_OFF_STATUS: regRdData <= statusWord;
                `SLTS_OFF_PWRDN:  regRdData <= {6'h00, pwrDn_r};
                default:          regRdData <= 8'h00;
            endcase
        end else begin
            // idle cycles read zero so stale data never lingers
            regRdData <= 8'h00;
        end
    end

    // ****************************************************
    // ila device numbers
    // ****************************************************
    // link B always carries the odd partner number
    assign ilaDevNumA = {devNum_r, 1'b0};
    assign ilaDevNumB = {devNum_r, 1'b1};

    // ****************************************************
    // test pattern mode decode
    // ****************************************************
    // one flag per mode handled by the lane framing logic
    assign testPatternSel    = testSel_r;
    assign ilaRepeatMode     = (testSel_r == `SLTS_TP_ILA);
    assign transportTestMode = (testSel_r == `SLTS_TP_TRANSPORT);
    assign rpatMode          = (testSel_r == `SLTS_TP_RPAT);
    assign laneForceLow      = (testSel_r == `SLTS_TP_LOW);
    assign laneForceHigh     = (testSel_r == `SLTS_TP_HIGH);

    // ****************************************************
    // pattern generators
    // ****************************************************
    // lfsr, ramp and rpat counters run only while the link is enabled and not both channels down
    // all-ones seed keeps the lfsr out of its lock-up state
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lfsr_r <= `SLTS_RST_LFSR;
            ramp_r <= 8'h00;
            rpat_r <= 8'h00;
        end else if (!linkActive) begin
            lfsr_r <= `SLTS_RST_LFSR;
            ramp_r <= 8'h00;
            rpat_r <= 8'h00;
        end else begin
            lfsr_r <= prbsAdvance(lfsr_r, testSel_r);
            ramp_r <= ramp_r + 8'h01;
            rpat_r <= rpat_r + 8'h35;
        end
    end

    // ****************************************************
    // lane byte source
    // ****************************************************
    // choose the outgoing byte and its control flag per mode
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            laneData_r <= 8'h00;
            laneIsK_r  <= 1'b0;
        end else if (!linkActive) begin
            laneData_r <= 8'h00;
            laneIsK_r  <= 1'b0;
        end else begin
            case (testSel_r)
                `SLTS_TP_NORMAL, `SLTS_TP_TRANSPORT, `SLTS_TP_ILA: begin
                    // end-of-frame byte only where monitoring allows
                    if (frameEndIn && eofPermitted) begin
                        laneData_r <= eofChar(frame_end_char_select_r);
                        laneIsK_r  <= 1'b1;
                    end else begin
                        laneData_r <= normalData;
                        laneIsK_r  <= 1'b0;
                    end
                end
                `SLTS_TP_PRBS7: begin
                    // short sequence fills the low seven bits only
                    laneData_r <= {1'b0, lfsr_r[6:0]};
                    laneIsK_r  <= 1'b0;
                end
                `SLTS_TP_PRBS15, `SLTS_TP_PRBS23: begin
                    laneData_r <= lfsr_r[7:0];
                    laneIsK_r  <= 1'b0;
                end
                `SLTS_TP_RAMP: begin
                    // ramp restarts from zero on each link enable
                    laneData_r <= ramp_r;
                    laneIsK_r  <= 1'b0;
                end
                `SLTS_TP_D215: begin
                    laneData_r <= `SLTS_CH_D215;
                    laneIsK_r  <= 1'b0;
                end
                `SLTS_TP_K285: begin
                    laneData_r <= `SLTS_CH_K285;
                    laneIsK_r  <= 1'b1;
                end
                `SLTS_TP_RPAT: begin
                    // coarse stand-in for the jitter pattern
                    laneData_r <= rpat_r;
                    laneIsK_r  <= 1'b0;
                end
                `SLTS_TP_HIGH: begin
                    laneData_r <= 8'hFF;
                    laneIsK_r  <= 1'b0;
                end
                default: begin
                    // low drive and reserved codes send zeros
                    laneData_r <= 8'h00;
                    laneIsK_r  <= 1'b0;
                end
            endcase
        end
    end

endmodule // slts_regs

// [include/slts_regs.vh]
// register offsets, field positions, reset values and codes of the link status bank
`ifndef SLTS_REGS_VH
`define SLTS_REGS_VH
// ****************************************************
// register offsets
// ****************************************************
`define SLTS_ADDR_W          10
`define SLTS_OFF_TEST        10'h205
`define SLTS_OFF_DEVNUM      10'h206
`define SLTS_OFF_FRAME_END_CHAR_SELECT       10'h207
`define SLTS_OFF_STATUS      10'h208
`define SLTS_OFF_PWRDN       10'h209
// ****************************************************
// reset values
// ****************************************************
`define SLTS_RST_TEST        4'h0
`define SLTS_RST_DEVNUM      7'h00
`define SLTS_RST_FRAME_END_CHAR_SELECT       2'h0
`define SLTS_RST_PWRDN       2'h0
`define SLTS_RST_LFSR        23'h7FFFFF
// ****************************************************
// field positions
// ****************************************************
`define SLTS_ST_LINKUP       6
`define SLTS_ST_SYNC         5
`define SLTS_ST_REALIGN      4
`define SLTS_ST_ALIGN        3
`define SLTS_ST_PLL          2
`define SLTS_PD_B            1
`define SLTS_PD_A            0
// ****************************************************
// test pattern codes
// ****************************************************
`define SLTS_TP_NORMAL       4'h0
`define SLTS_TP_PRBS7        4'h1
`define SLTS_TP_PRBS15       4'h2
`define SLTS_TP_PRBS23       4'h3
`define SLTS_TP_RAMP         4'h4
`define SLTS_TP_TRANSPORT    4'h5
`define SLTS_TP_D215         4'h6
`define SLTS_TP_K285         4'h7
`define SLTS_TP_ILA          4'h8
`define SLTS_TP_RPAT         4'h9
`define SLTS_TP_LOW          4'hA
`define SLTS_TP_HIGH         4'hB
// ****************************************************
// 8b/10b character bytes
// ****************************************************
`define SLTS_CH_D215         8'hB5
`define SLTS_CH_K285         8'hBC
`define SLTS_CH_K287         8'hFC
`define SLTS_CH_K281         8'h3C
`define SLTS_FC_K287         2'h0
`define SLTS_FC_K281         2'h1
`define SLTS_FC_K285         2'h2
`endif

// [tb/slts_regs_asserts.sv]
// concurrent checks on the ports of the link status register bank
`timescale 1ns/1ps
module slts_regs_asserts (
    input wire       ref_clk,
    input wire       rst,
    input wire [9:0] regAddr,
    input wire       regRdStb,
    input wire [7:0] regRdData,
    input wire       syncNIn,
    input wire [7:0] normalData,
    input wire       frameEndIn,
    input wire       eofPermitted,
    input wire [3:0] testPatternSel,
    input wire [7:0] laneData_r,
    input wire       laneIsK_r,
    input wire       laneForceLow,
    input wire       laneForceHigh,
    input wire       ilaRepeatMode,
    input wire       transportTestMode,
    input wire       rpatMode,
    input wire [7:0] ilaDevNumA,
    input wire [7:0] ilaDevNumB,
    input wire       chanAPowerDown,
    input wire       chanBPowerDown,
    input wire       laneAPowerDown,
    input wire       laneBPowerDown,
    input wire       subsysPowerDown,
    input wire       linkLogicReset
);
    // ****************************************************
    // clocking and reset
    // ****************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ****************************************************
    // assertions
    // ****************************************************
    chk_rd_idle: assert property (!$past(regRdStb) |-> regRdData == 8'h00)
        else $error("read data not zero outside read cycle");
    chk_devnum_pair: assert property (ilaDevNumA[0] == 1'b0
        && ilaDevNumB == {ilaDevNumA[7:1], 1'b1})
        else $error("device number pair wrong");
    chk_held_levels: assert property (laneForceLow == (testPatternSel == 4'hA)
        && laneForceHigh == (testPatternSel == 4'hB))
        else $error("held level outputs wrong");
    chk_mode_flags: assert property (ilaRepeatMode == (testPatternSel == 4'h8)
        && rpatMode == (testPatternSel == 4'h9) && transportTestMode == (testPatternSel == 4'h5))
        else $error("mode flags wrong");
    chk_d215_char: assert property (!linkLogicReset && testPatternSel == 4'h6
        |=> laneData_r == 8'hB5 && !laneIsK_r)
        else $error("repeated data character wrong");
    chk_k285_char: assert property (!linkLogicReset && testPatternSel == 4'h7
        |=> laneData_r == 8'hBC && laneIsK_r)
        else $error("repeated comma character wrong");
    chk_ramp_step: assert property (!linkLogicReset && testPatternSel == 4'h4
        ##1 !linkLogicReset && testPatternSel == 4'h4
        |=> laneData_r == 8'($past(laneData_r) + 8'h01))
        else $error("ramp step wrong");
    chk_link_held: assert property (linkLogicReset |=> laneData_r == 8'h00 && !laneIsK_r)
        else $error("lane active while link held");
    chk_both_down: assert property (chanAPowerDown && chanBPowerDown |-> subsysPowerDown && linkLogicReset)
        else $error("subsystem not powered down");
    chk_lane_down: assert property ((!chanAPowerDown || laneAPowerDown)
        && (!chanBPowerDown || laneBPowerDown))
        else $error("lane power-down missing");
    chk_eof_insert: assert property (!linkLogicReset && testPatternSel == 4'h0
        && frameEndIn && eofPermitted |=> laneIsK_r)
        else $error("end-of-frame character not inserted");
    chk_normal_pass: assert property (!linkLogicReset && testPatternSel == 4'h0 && !frameEndIn
        |=> laneData_r == $past(normalData) && !laneIsK_r)
        else $error("normal data not passed");
    chk_sync_live: assert property (regRdStb && regAddr == 10'h208 |=> regRdData[5] == $past(syncNIn))
        else $error("sync status bit wrong");
    // ****************************************************
    // covers
    // ****************************************************
    cov_eof: cover property (!linkLogicReset && testPatternSel == 4'h0 && frameEndIn && eofPermitted);
    cov_ramp: cover property (!linkLogicReset && testPatternSel == 4'h4);
    cov_status: cover property (regRdStb && regAddr == 10'h208);
endmodule // slts_regs_asserts

bind slts_regs slts_regs_asserts chk_u (.*);

// [tb/slts_rx_model.sv]
// receiver model at the far end of the serial lanes
`timescale 1ns/1ps
module slts_rx_model (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       laneIsK_r,
    input  wire       linkLogicReset,
    input  wire       holdSync,
    output logic      syncNIn,
    output logic [7:0] kCount
);
    logic [1:0] waitCnt_r;
    // sync request held while link is down, released a few cycles after it runs
    always @(posedge ref_clk or posedge rst) begin
        if (rst || linkLogicReset || holdSync) begin
            syncNIn   <= 1'b0;
            waitCnt_r <= 2'h0;
        end else if (waitCnt_r != 2'h3) begin
            waitCnt_r <= waitCnt_r + 2'h1;
        end else begin
            syncNIn <= 1'b1;
        end
    end
    // count of control characters received
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            kCount <= 8'h00;
        end else if (laneIsK_r) begin
            kCount <= kCount + 8'h01;
        end
    end
endmodule // slts_rx_model

// [tb/tb_top.sv]
// self-checking bench of the link status register bank
`timescale 1ns/1ps
module tb_top;
    logic       ref_clk = 1'b0, rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0, serialLinkEnable = 1'b0;
    logic       linkUpIn = 1'b0, sysrefEvent = 1'b0, sysrefPhaseShift = 1'b0, pllLockedIn = 1'b0;
    logic       frameEndIn = 1'b0, eofPermitted = 1'b0, holdSync = 1'b0, syncNIn, laneIsK_r;
    logic [9:0] regAddr = 10'h000;
    logic [7:0] regWrData = 8'h00, normalData = 8'h00, regRdData, laneData_r, ilaDevNumA, ilaDevNumB, kCount;
    logic [3:0] testPatternSel;
    logic       laneForceLow, laneForceHigh, ilaRepeatMode, transportTestMode, rpatMode, chanAPowerDown;
    logic       chanBPowerDown, laneAPowerDown, laneBPowerDown, subsysPowerDown, linkLogicReset, chanBSlotsUndefined;
    int         failures = 0, totalChecks = 0;
    always #2.5 ref_clk = ~ref_clk;
    slts_regs dut_u (.*);
    slts_rx_model rx_u (.*);
    // ****************************************************
    // shared tasks
    // ****************************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge ref_clk);
        regWrStb  <= 1'b0;
    endtask
    task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge ref_clk);
        regRdStb <= 1'b0;
        #1 chk(regRdData, e);
    endtask
    task automatic lanes(input logic en, input logic fe, input logic ep, input logic [7:0] nd);
        @(posedge ref_clk);
        serialLinkEnable <= en;
        frameEndIn       <= fe;
        eofPermitted     <= ep;
        normalData       <= nd;
    endtask
    task automatic pulse(input bit ph);
        @(posedge ref_clk);
        sysrefPhaseShift <= ph;
        sysrefEvent      <= !ph;
        @(posedge ref_clk);
        sysrefPhaseShift <= 1'b0;
        sysrefEvent      <= 1'b0;
    endtask
    task automatic waitsync;
        for (int n = 0; n < 20 && syncNIn !== 1'b1; n++) cyc(1);
        if (syncNIn !== 1'b1) begin
            failures++;
            end_of_test;
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_reset;
        rdchk(10'h205, 8'h00);
        rdchk(10'h206, 8'h00);
        rdchk(10'h207, 8'h00);
        rdchk(10'h209, 8'h00);
        wr(10'h20A, 8'hFF);
        rdchk(10'h20A, 8'h00);
        wr(10'h206, 8'h05);
        rdchk(10'h206, 8'h04);
        chk(ilaDevNumB, 8'h05);
        wr(10'h206, 8'hFF);
        rdchk(10'h206, 8'hFE);
        chk(ilaDevNumA, 8'hFE);
        $display("test reset and device number done");
    endtask
    task automatic t_patterns;
        logic [7:0] prev;
        for (int i = 0; i < 12; i++) begin
            lanes(1'b0, 1'b0, 1'b0, 8'h5A);
            wr(10'h205, 8'(i));
            rdchk(10'h205, 8'(i));
            chk({5'h0, ilaRepeatMode, transportTestMode, rpatMode},
                {5'h0, i == 8, i == 5, i == 9});
            chk({6'h0, laneForceLow, laneForceHigh}, {6'h0, i == 10, i == 11});
            lanes(1'b1, 1'b0, 1'b0, 8'h5A);
            cyc(2);
            prev = laneData_r;
            cyc(1);
            case (i)
                0, 5, 8: chk(laneData_r, 8'h5A);
                1: chk(laneData_r, 8'h0C);
                2: chk(laneData_r, 8'h02);
                3: chk(laneData_r, 8'h00);
                4: chk(laneData_r, prev + 8'h01);
                6: chk({laneData_r[7:1], laneIsK_r}, 8'hB4);
                7: chk({laneData_r[7:1], laneIsK_r}, 8'hBD);
                9: chk(laneData_r, prev + 8'h35);
                10: chk(laneData_r, 8'h00);
                11: chk(laneData_r, 8'hFF);
                default: ;
            endcase
        end
        $display("test patterns done");
    endtask
    task automatic t_eof;
        logic [7:0] ch [3] = '{8'hFC, 8'h3C, 8'hBC};
        logic [7:0] k0;
        lanes(1'b0, 1'b0, 1'b0, 8'h33);
        wr(10'h205, 8'h00);
        k0 = kCount;
        for (int f = 0; f < 3; f++) begin
            lanes(1'b0, 1'b0, 1'b0, 8'h33);
            wr(10'h207, 8'(f));
            rdchk(10'h207, 8'(f));
            lanes(1'b1, 1'b1, 1'b1, 8'h33);
            cyc(1);
            chk({laneData_r[7:1], laneIsK_r}, {ch[f][7:1], 1'b1});
            lanes(1'b1, 1'b1, 1'b0, 8'h33);
            cyc(1);
            chk(laneData_r, 8'h33);
        end
        lanes(1'b0, 1'b0, 1'b0, 8'h33);
        wr(10'h207, 8'h00);
        chk(kCount, k0 + 8'h06);
        $display("test end of frame done");
    endtask
    task automatic t_status;
        lanes(1'b1, 1'b0, 1'b0, 8'h00);
        pllLockedIn <= 1'b1;
        linkUpIn    <= 1'b1;
        waitsync;
        rdchk(10'h208, 8'h64);
        pulse(1'b0);
        rdchk(10'h208, 8'h6C);
        wr(10'h208, 8'h00);
        rdchk(10'h208, 8'h6C);
        wr(10'h208, 8'h08);
        pulse(1'b0);
        rdchk(10'h208, 8'h64);
        pulse(1'b1);
        wr(10'h208, 8'hE7);
        rdchk(10'h208, 8'h74);
        wr(10'h208, 8'h10);
        @(posedge ref_clk);
        holdSync <= 1'b1;
        rdchk(10'h208, 8'h44);
        lanes(1'b0, 1'b0, 1'b0, 8'h00);
        holdSync <= 1'b0;
        pulse(1'b0);
        pulse(1'b1);
        rdchk(10'h208, 8'h04);
        lanes(1'b1, 1'b0, 1'b0, 8'h00);
        waitsync;
        pulse(1'b0);
        rdchk(10'h208, 8'h6C);
        wr(10'h208, 8'h08);
        $display("test status done");
    endtask
    task automatic t_power;
        for (int p = 1; p < 4; p++) begin
            lanes(1'b0, 1'b0, 1'b0, 8'h00);
            wr(10'h209, 8'(p));
            rdchk(10'h209, 8'(p));
            lanes(1'b1, 1'b0, 1'b0, 8'h00);
            cyc(1);
            chk({2'h0, chanBPowerDown, chanAPowerDown, laneBPowerDown, laneAPowerDown,
                subsysPowerDown, linkLogicReset}, {2'h0, p[1], p[0], p[1], p[0], p == 3, p == 3});
            chk({7'h00, chanBSlotsUndefined}, {7'h00, p == 2});
        end
        rdchk(10'h208, 8'h00);
        $display("test power down done");
    endtask
    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_patterns;
        t_eof;
        t_status;
        t_power;
        end_of_test;
    end
endmodule // tb_top
